// ===== hw/timer8_pwm.sv
`timescale 1ns/10ps
`include "timer8_pwm_consts.svh"
// Functional notes
// R1: Modes 3 and 7 run single-slope fast PWM.
// R2: Fast TOP is 0xFF or compare A.
// R3: Fast count climbs to TOP, then clears.
// R4: Fast inverting sets on match, clears BOTTOM.
// R5: Output mode two non-inverted, three inverted.
// R6: Fast PWM sets overflow at TOP.
// R7: Fast toggle on A only with mode bit2.
// R8: Fast second edge lands on TOP wrap.
// R9: Fast extremes: spike at BOTTOM, constant at MAX.
// R10: Fast toggle gives square wave, double-buffered.
// R11: Modes 1 and 5 phase correct, TOP chosen.
// R12: Phase correct up to TOP, then straight down.
// R13: Phase correct clears up-match, sets down-match.
// R14: Phase correct sets overflow at BOTTOM.
// R15: Phase correct toggle on A only, bit2.
// R16: Phase correct extremes give constant levels.
// R17: Leaving MAX forces up-level at BOTTOM.
// R18: Missed up-match forces transition at BOTTOM.
// R19: Fully synchronous; tick is only an enable.
// R20: Tick divides clock by 1..1024.
// R21: Periods N*256 fast, N*510 phase.
// R22: Control A layout, reserved zero, reset zero.
// R23: Output mode nonzero overrides port; direction enables.
// R24: Compare equal TOP acts at TOP instead.
// R25: PWM compare updates at TOP, else immediately.
// R26: Reset clears compare output registers.
module timer8_pwm
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire timer8_pwm_pkg::bus_req_t bus_req_i,
  output logic [7:0] rd_data_o,
  input wire logic [1:0] port_data_i,
  input wire logic [1:0] pin_dir_i,
  output timer8_pwm_pkg::pin_drive_t chan_a_pin_o,
  output timer8_pwm_pkg::pin_drive_t chan_b_pin_o
);
  import timer8_pwm_pkg::*;

  // --------------------------------------------------------------------------
  // Registers and decode
  // --------------------------------------------------------------------------
  logic [7:0] wca_reg;
  logic [3:0] wcb_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  count_dir_t dir_reg;
  count_dir_t dir_next;
  logic [2:0] flags_reg;
  logic [2:0] flags_set;
  logic block_reg;
  logic [9:0] psc_reg;
  logic [7:0] rd_value;
  logic wr_wca;
  logic wr_wcb;
  logic wr_cnt;
  logic wr_flags;
  logic [2:0] mode_sel;
  wave_kind_t wave_kind;
  logic pwm_mode;
  logic [7:0] top_value;
  logic at_top;
  logic at_bottom;
  logic [2:0] psc_sel;
  logic [9:0] psc_mask;
  logic psc_run;
  logic timer_tick;
  logic ovf_event;
  logic load_point;

  assign wr_wca = bus_req_i.wr && (bus_req_i.addr == `WCA_OFFSET);
  assign wr_wcb = bus_req_i.wr && (bus_req_i.addr == `WCB_OFFSET);
  assign wr_cnt = bus_req_i.wr && (bus_req_i.addr == `CNT_OFFSET);
  assign wr_flags = bus_req_i.wr && (bus_req_i.addr == `FLAGS_OFFSET);

  // --------------------------------------------------------------------------
  // Mode and TOP selection
  // --------------------------------------------------------------------------
  assign mode_sel = {wcb_reg[`WCB_MODE_BIT2], wca_reg[`WGM_LOW_LSB +: 2]};
  assign wave_kind = (mode_sel == `MODE_FAST_FIXED || mode_sel == `MODE_FAST_VAR) ? KIND_FAST : // R1
                     (mode_sel == `MODE_PC_FIXED || mode_sel == `MODE_PC_VAR) ? KIND_PHASE : // R11
                     (mode_sel == `MODE_CTC) ? KIND_CTC : KIND_NORMAL;
  assign pwm_mode = (wave_kind == KIND_FAST) || (wave_kind == KIND_PHASE);
  // Variable TOP comes from the active (buffered) compare A value.
  assign top_value = (mode_sel[2] || wave_kind == KIND_CTC) ? chan_gen[0].cmp_act_reg : `COUNT_MAX; // R2 R11
  assign at_top = (count_reg == top_value);
  assign at_bottom = (count_reg == `COUNT_BOTTOM);

  // --------------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------------
  // The divider is free running, so a new factor takes effect at the next
  // aligned boundary rather than restarting the division.
  assign psc_sel = wcb_reg[2:0];
  assign psc_run = (psc_sel >= `PSC_SEL_DIV1) && (psc_sel <= `PSC_SEL_DIV1024);
  assign psc_mask = (psc_sel == `PSC_SEL_DIV8) ? `PSC_MASK_DIV8 :
                    (psc_sel == `PSC_SEL_DIV64) ? `PSC_MASK_DIV64 :
                    (psc_sel == `PSC_SEL_DIV256) ? `PSC_MASK_DIV256 :
                    (psc_sel == `PSC_SEL_DIV1024) ? `PSC_MASK_DIV1024 : `PSC_MASK_DIV1;
  assign timer_tick = psc_run && ((psc_reg & psc_mask) == psc_mask); // R20 R21

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      psc_reg <= 10'h000;
    else
      psc_reg <= psc_reg + 10'h001;
  end

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  always_comb
  begin
    count_next = count_reg;
    dir_next = dir_reg;
    if (wr_cnt)
      count_next = bus_req_i.wdata;
    else if (timer_tick && wave_kind == KIND_PHASE) // R19
    begin
      if (dir_reg == DIR_UP && at_top) // R12
      begin
        dir_next = DIR_DOWN;
        count_next = count_reg - 8'h01;
      end
      else if (dir_reg == DIR_DOWN && at_bottom)
      begin
        dir_next = DIR_UP;
        count_next = count_reg + 8'h01;
      end
      else
        count_next = (dir_reg == DIR_UP) ? count_reg + 8'h01 : count_reg - 8'h01;
    end
    else if (timer_tick)
      count_next = at_top ? `COUNT_BOTTOM : count_reg + 8'h01; // R3
    if (!pwm_mode)
      dir_next = DIR_UP;
  end

  assign ovf_event = timer_tick && ((wave_kind == KIND_FAST) ? at_top : // R6
                     (wave_kind == KIND_PHASE) ? (dir_reg == DIR_DOWN && at_bottom) : // R14
                     (count_reg == `COUNT_MAX));
  assign load_point = pwm_mode ? (timer_tick && at_top) : 1'b1; // R25 R10

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_reg <= `COUNT_BOTTOM;
      dir_reg <= DIR_UP;
    end
    else
    begin
      count_reg <= count_next;
      dir_reg <= dir_next;
    end
  end

  // A counter write blocks compare matches until the next tick has passed.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      block_reg <= 1'b0;
    else if (wr_cnt)
      block_reg <= 1'b1;
    else if (timer_tick)
      block_reg <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Control and flag registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wca_reg <= `WCA_RESET; // R22
      wcb_reg <= `WCB_RESET;
    end
    else
    begin
      if (wr_wca)
        wca_reg <= bus_req_i.wdata & `WCA_WRITE_MASK; // R22
      if (wr_wcb)
        wcb_reg <= bus_req_i.wdata[3:0];
    end
  end

  assign flags_set = {chan_gen[1].match, chan_gen[0].match, ovf_event};

  // Writing one clears a flag; a flag event in the same cycle wins.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      flags_reg <= 3'h0;
    else
      flags_reg <= (flags_reg & ~(wr_flags ? bus_req_i.wdata[2:0] : 3'h0)) | flags_set;
  end

  // --------------------------------------------------------------------------
  // Compare channels
  // --------------------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : chan_gen
    localparam int MODE_LSB = (ch == 0) ? `CHA_MODE_LSB : `CHB_MODE_LSB;
    localparam logic [7:0] CMP_OFFSET = (ch == 0) ? `CMPA_OFFSET : `CMPB_OFFSET;
    logic [7:0] cmp_buf_reg;
    logic [7:0] cmp_act_reg;
    logic oc_reg;
    logic oc_next;
    logic up_done_reg;
    logic [1:0] out_mode;
    logic match;
    logic top_case;
    logic toggle_ok;
    logic counting_up;
    pin_drive_t pin_reg;

    assign out_mode = wca_reg[MODE_LSB +: 2];
    assign match = timer_tick && !block_reg && (count_reg == cmp_act_reg);
    assign top_case = pwm_mode && out_mode[1] && (cmp_act_reg == top_value); // R24
    // Only channel A may toggle in the PWM modes, and only with mode bit 2.
    assign toggle_ok = (out_mode == `COM_TOGGLE) && (!pwm_mode || (ch == 0 && mode_sel[2])); // R7 R15
    // A match at BOTTOM opens the up slope.
    assign counting_up = (dir_reg == DIR_UP) || at_bottom;

    always_comb
    begin
      oc_next = oc_reg;
      if (wave_kind == KIND_FAST && out_mode[1]) // R5
      begin
        if (timer_tick && at_top)
          oc_next = ~out_mode[0]; // R4 R8 R9
        else if (match)
          oc_next = out_mode[0]; // R4
      end
      else if (wave_kind == KIND_PHASE && out_mode[1]) // R5
      begin
        if (timer_tick && dir_reg == DIR_DOWN && at_bottom && !top_case && !up_done_reg)
          oc_next = out_mode[0]; // R17 R18
        if (top_case)
        begin
          if (timer_tick && at_top)
            oc_next = ~out_mode[0]; // R16
        end
        else if (match)
          oc_next = counting_up ? out_mode[0] : ~out_mode[0]; // R13 R16
      end
      else if (toggle_ok && match)
        oc_next = ~oc_reg; // R10
      else if (!pwm_mode && out_mode[1] && match)
        oc_next = out_mode[0];
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        cmp_buf_reg <= `COUNT_BOTTOM;
        cmp_act_reg <= `COUNT_BOTTOM;
        oc_reg <= 1'b0; // R26
        up_done_reg <= 1'b0;
        pin_reg <= '0;
      end
      else
      begin
        if (bus_req_i.wr && bus_req_i.addr == CMP_OFFSET)
          cmp_buf_reg <= bus_req_i.wdata;
        if (load_point)
          cmp_act_reg <= cmp_buf_reg; // R25
        oc_reg <= oc_next;
        if (timer_tick && dir_reg == DIR_DOWN && at_bottom)
          up_done_reg <= match;
        else if (match && counting_up && !top_case)
          up_done_reg <= 1'b1;
        pin_reg.value <= (out_mode != `COM_OFF) ? oc_reg : port_data_i[ch]; // R23
        pin_reg.enable <= pin_dir_i[ch]; // R23
      end
    end
  end

  assign chan_a_pin_o = chan_gen[0].pin_reg;
  assign chan_b_pin_o = chan_gen[1].pin_reg;

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  assign rd_value = (bus_req_i.addr == `WCA_OFFSET) ? wca_reg : // R22
                    (bus_req_i.addr == `WCB_OFFSET) ? {4'h0, wcb_reg} :
                    (bus_req_i.addr == `CNT_OFFSET) ? count_reg :
                    (bus_req_i.addr == `CMPA_OFFSET) ? chan_gen[0].cmp_buf_reg :
                    (bus_req_i.addr == `CMPB_OFFSET) ? chan_gen[1].cmp_buf_reg :
                    (bus_req_i.addr == `FLAGS_OFFSET) ? {5'h00, flags_reg} : 8'h00;

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      rd_data_o <= 8'h00;
    else
      rd_data_o <= bus_req_i.rd ? rd_value : 8'h00;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_fast_top;
    wave_kind == KIND_FAST && timer_tick && at_top && !wr_cnt;
  endsequence

  sequence s_phase_turn;
    wave_kind == KIND_PHASE && timer_tick && dir_reg == DIR_UP && at_top && !at_bottom && !wr_cnt;
  endsequence

  property p_fast_wrap;
    @(posedge clock_i) disable iff (reset_i)
    s_fast_top |=> count_reg == `COUNT_BOTTOM;
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast count did not wrap at top"); // R3

  property p_fast_inc;
    @(posedge clock_i) disable iff (reset_i)
    wave_kind == KIND_FAST && timer_tick && !at_top && !wr_cnt |=> count_reg == $past(count_reg) + 8'h01;
  endproperty
  a_fast_inc: assert property (p_fast_inc) else $error("fast count did not increment"); // R3

  property p_fast_ovf;
    @(posedge clock_i) disable iff (reset_i)
    s_fast_top |=> flags_reg[`FLAG_OVF_BIT];
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("overflow not set at fast top"); // R6

  property p_fast_edge;
    @(posedge clock_i) disable iff (reset_i)
    s_fast_top ##0 (wca_reg[`CHA_MODE_LSB +: 2] == `COM_NONINV) |=> chan_gen[0].oc_reg ##1 chan_a_pin_o.value
      || $past(wca_reg[`CHA_MODE_LSB +: 2]) != `COM_NONINV;
  endproperty
  a_fast_edge: assert property (p_fast_edge) else $error("non-inverted output not set at wrap"); // R8

  property p_phase_turn;
    @(posedge clock_i) disable iff (reset_i)
    s_phase_turn |=> dir_reg == DIR_DOWN && count_reg == $past(count_reg) - 8'h01;
  endproperty
  a_phase_turn: assert property (p_phase_turn) else $error("phase count did not turn at top"); // R12

  property p_phase_ovf;
    @(posedge clock_i) disable iff (reset_i)
    wave_kind == KIND_PHASE && timer_tick && dir_reg == DIR_DOWN && at_bottom |=> flags_reg[`FLAG_OVF_BIT];
  endproperty
  a_phase_ovf: assert property (p_phase_ovf) else $error("overflow not set at phase bottom"); // R14

  property p_var_top;
    @(posedge clock_i) disable iff (reset_i)
    mode_sel == `MODE_PC_VAR || mode_sel == `MODE_FAST_VAR |-> top_value == chan_gen[0].cmp_act_reg;
  endproperty
  a_var_top: assert property (p_var_top) else $error("variable top not compare A"); // R2

  property p_buffer_hold;
    @(posedge clock_i) disable iff (reset_i)
    pwm_mode && !(timer_tick && at_top) |=> $stable(chan_gen[0].cmp_act_reg);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("compare changed away from top"); // R25

  property p_reserved_zero;
    @(posedge clock_i) disable iff (reset_i)
    bus_req_i.rd && bus_req_i.addr == `WCA_OFFSET |=> rd_data_o[3:2] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero"); // R22

  property p_pin_dir;
    @(posedge clock_i) disable iff (reset_i)
    !reset_i |=> chan_b_pin_o.enable == $past(pin_dir_i[1]);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin enable does not follow direction"); // R23

endmodule // timer8_pwm

// ===== inc/timer8_pwm_consts.svh
`ifndef TIMER8_PWM_CONSTS_SVH
`define TIMER8_PWM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define WCA_OFFSET 8'h00
`define WCB_OFFSET 8'h01
`define CNT_OFFSET 8'h02
`define CMPA_OFFSET 8'h03
`define CMPB_OFFSET 8'h04
`define FLAGS_OFFSET 8'h05

// ----------------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------------
`define WCA_RESET 8'h00
`define WCB_RESET 4'h0
`define WCA_WRITE_MASK 8'hF3
`define CHA_MODE_LSB 6
`define CHB_MODE_LSB 4
`define WGM_LOW_LSB 0
`define WCB_MODE_BIT2 3
`define FLAG_OVF_BIT 0
`define FLAG_MA_BIT 1
`define FLAG_MB_BIT 2

// ----------------------------------------------------------------------------
// Counter limits, mode and output mode codes
// ----------------------------------------------------------------------------
`define COUNT_BOTTOM 8'h00
`define COUNT_MAX 8'hFF
`define MODE_PC_FIXED 3'h1
`define MODE_CTC 3'h2
`define MODE_FAST_FIXED 3'h3
`define MODE_PC_VAR 3'h5
`define MODE_FAST_VAR 3'h7
`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_NONINV 2'h2

// ----------------------------------------------------------------------------
// Prescale select codes and divider masks
// ----------------------------------------------------------------------------
`define PSC_SEL_DIV1 3'h1
`define PSC_SEL_DIV8 3'h2
`define PSC_SEL_DIV64 3'h3
`define PSC_SEL_DIV256 3'h4
`define PSC_SEL_DIV1024 3'h5
`define PSC_MASK_DIV1 10'h000
`define PSC_MASK_DIV8 10'h007
`define PSC_MASK_DIV64 10'h03F
`define PSC_MASK_DIV256 10'h0FF
`define PSC_MASK_DIV1024 10'h3FF

`endif

// ===== inc/timer8_pwm_pkg.sv
package timer8_pwm_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic value;
    logic enable;
  } pin_drive_t;

  typedef enum logic [1:0] {KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_PHASE} wave_kind_t;

  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

endpackage

// ===== test/pin_load.sv
`timescale 1ns/10ps
module pin_load
(
  input wire logic clock_i,
  input wire logic clear_i,
  input wire timer8_pwm_pkg::pin_drive_t drive_i,
  output logic level_o,
  output logic [15:0] high_count_o
);
  import timer8_pwm_pkg::*;

  // The filter stage has a pull-down, so a released pin reads low, never the last driven value.
  assign level_o = drive_i.enable ? drive_i.value : 1'b0;

  // Counting high cycles gives the average the filter would see, independent of edge placement.
  always_ff @(posedge clock_i)
  begin
    if (clear_i)
      high_count_o <= 16'h0000;
    else if (level_o === 1'b1)
      high_count_o <= high_count_o + 16'h0001;
  end
endmodule // pin_load

// ===== test/timer8_pwm_waveform_modes_bench.sv
`timescale 1ns/10ps
`include "timer8_pwm_consts.svh"
module timer8_pwm_waveform_modes_bench;
  import timer8_pwm_pkg::*;

  logic clock_i;
  logic reset_i;
  bus_req_t bus_req_i;
  logic [7:0] rd_data_o;
  logic [1:0] port_data_i;
  logic [1:0] pin_dir_i;
  pin_drive_t chan_a_pin_o;
  pin_drive_t chan_b_pin_o;
  logic clear_count;
  logic level_a;
  logic level_b;
  logic [15:0] highs_a;
  logic [15:0] highs_b;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  timer8_pwm u_timer8_pwm (.clock_i(clock_i), .reset_i(reset_i), .bus_req_i(bus_req_i), .rd_data_o(rd_data_o),
    .port_data_i(port_data_i), .pin_dir_i(pin_dir_i), .chan_a_pin_o(chan_a_pin_o), .chan_b_pin_o(chan_b_pin_o));
  pin_load u_pin_load_a (.clock_i(clock_i), .clear_i(clear_count), .drive_i(chan_a_pin_o), .level_o(level_a),
    .high_count_o(highs_a));
  pin_load u_pin_load_b (.clock_i(clock_i), .clear_i(clear_count), .drive_i(chan_b_pin_o), .level_o(level_b),
    .high_count_o(highs_b));

  // --------------------------------------------------------------------------
  // Clock and watchdog
  // --------------------------------------------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // All tests together take about 13600 cycles; the ceiling leaves ample margin.
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      $display("ERROR at %0t: run did not finish in time", $time);
      print_verdict();
    end
  end

  // --------------------------------------------------------------------------
  // Bus and compare tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // A gap cycle follows each strobe so the bus signal is never assigned twice in one step.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    bus_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus_req_i <= '0;
    @(posedge clock_i);
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    bus_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus_req_i <= '0;
    #1;
    check({8'h00, rd_data_o & mask}, {8'h00, exp}, "register read");
    @(posedge clock_i);
  endtask

  // Stops the timer, sets it up from zero, lets it settle for two periods, then measures one.
  task automatic run(input logic [7:0] ctrl_a, input logic [7:0] ctrl_b, input logic [7:0] cmp_a,
    input logic [7:0] cmp_b, input int period, input logic [15:0] exp_a, input logic [15:0] exp_b);
    reg_write(`WCB_OFFSET, 8'h00);
    reg_write(`WCA_OFFSET, 8'h00);
    reg_write(`CNT_OFFSET, 8'h00);
    reg_write(`CMPA_OFFSET, cmp_a);
    reg_write(`CMPB_OFFSET, cmp_b);
    reg_write(`WCA_OFFSET, ctrl_a);
    reg_write(`WCB_OFFSET, ctrl_b);
    repeat (2 * period) @(posedge clock_i);
    reg_write(`FLAGS_OFFSET, 8'h07);
    clear_count <= 1'b1;
    @(posedge clock_i);
    clear_count <= 1'b0;
    repeat (period) @(posedge clock_i);
    #1;
    check(highs_a, exp_a, "channel A high cycles");
    check(highs_b, exp_b, "channel B high cycles");
    @(posedge clock_i);
    reg_read(`FLAGS_OFFSET, 8'h07, 8'h07);
    $display("Test done: control %h/%h compare %h/%h", ctrl_a, ctrl_b, cmp_a, cmp_b);
  endtask

  task automatic print_verdict();
    $display("Checks made %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    reset_i = 1'b1;
    bus_req_i = '0;
    port_data_i = 2'b10;
    pin_dir_i = 2'b11;
    clear_count = 1'b0;
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    reg_read(`WCA_OFFSET, 8'hFF, 8'h00);
    reg_write(`WCA_OFFSET, 8'hFF);
    reg_read(`WCA_OFFSET, 8'hFF, 8'hF3);
    reg_read(8'h07, 8'hFF, 8'h00);
    $display("Test done: control register layout");
    run(8'hB3, 8'h01, 8'h80, 8'h40, 256, 16'd129, 16'd191);
    run(8'hB3, 8'h02, 8'h80, 8'h40, 2048, 16'd1032, 16'd1528);
    run(8'hA3, 8'h01, 8'hFF, 8'h00, 256, 16'd256, 16'd1);
    run(8'h43, 8'h09, 8'h00, 8'h00, 256, 16'd128, 16'd256);
    run(8'hB1, 8'h01, 8'h40, 8'h20, 510, 16'd128, 16'd446);
    run(8'hB1, 8'h01, 8'hFF, 8'h00, 510, 16'd510, 16'd510);
    // Channel A leaves the test above high; starting above the compare value misses the up match.
    reg_write(`WCB_OFFSET, 8'h00);
    reg_write(`WCA_OFFSET, 8'h00);
    reg_write(`CMPA_OFFSET, 8'h40);
    reg_write(`CNT_OFFSET, 8'h80);
    reg_read(`CNT_OFFSET, 8'hFF, 8'h80);
    reg_read(`CMPA_OFFSET, 8'hFF, 8'h40);
    reg_write(`WCA_OFFSET, 8'hB1);
    reg_write(`WCB_OFFSET, 8'h01);
    repeat (347) @(posedge clock_i);
    #1;
    check({15'h0000, chan_a_pin_o.value}, 16'h0001, "channel A before bottom");
    repeat (60) @(posedge clock_i);
    #1;
    check({15'h0000, chan_a_pin_o.value}, 16'h0000, "channel A after bottom");
    @(posedge clock_i);
    $display("Test done: bottom symmetry");
    run(8'h61, 8'h09, 8'h80, 8'h40, 512, 16'd256, 16'd256);
    pin_dir_i <= 2'b01;
    @(posedge clock_i);
    @(posedge clock_i);
    #1;
    check({15'h0000, chan_a_pin_o.enable}, 16'h0001, "channel A driver enable");
    check({15'h0000, chan_b_pin_o.enable}, 16'h0000, "channel B driver enable");
    $display("Test done: pin direction");
    print_verdict();
  end
endmodule // timer8_pwm_waveform_modes_bench
